// file: rtl/uhrd_run_debug_status.sv
// Run/stop, single-step debug and controller status register
// Operation
// - Debug off, run cleared: finish command, stop, reset frame counter, restart at SOF.
// - Debug off, run set: execute list from SOF until run control clears.
// - Debug on, run cleared: finish command, stop, freeze frame counter, keep status.
// - Debug on, run set: resume; clear run control when an active descriptor completes.
// - Debug stepping skips inactive descriptors, halts after an active one.
// - After last active descriptor of frame, wait SOF, fetch next, then halt.
// - Single-stepped descriptor finishing sets the halted flag, status bit 5.
// - Halted flag set after run cleared and transaction done; set at reset.
// - Status flags clear on writing one; reset value 0020h; no bus status.
// - Consistency failure sets bit 4, clears run control, raises interrupt.
// - Host bus failure sets bit 3, clears run control, raises interrupt.
// - Resume signaling sets bit 2; meaningful only in global suspend.
// - Transaction error sets bit 1; with completion request also bit 0.
// - Completion request or enabled short packet sets bit 0.
// - Run cleared: finish bus transaction first; fatal errors clear run control.
`timescale 1ns/100ps
`include "uhrd_consts.svh"
module uhrd_run_debug_status
    import uhrd_pkg::*;
#(
    parameter int FRAME_CYCLES = `UHRD_FRAME_CYC
) (
    input  wire logic               core_clk_i,
    input  wire logic               arst_n_i,
    input  wire logic [7:0]         io_addr_i,
    input  wire logic               io_wr_i,
    input  wire logic               io_rd_i,
    input  wire logic [15:0]        io_wdata_i,
    output logic      [15:0]        io_rdata_o,
    input  wire logic               td_valid_i,
    input  wire uhrd_td_result_type td_result_i,
    input  wire logic               consist_err_i,
    input  wire logic               host_bus_err_i,
    input  wire logic               resume_pin_i,
    output logic                    td_fetch_o,
    output logic                    sof_o,
    output logic                    irq_o
);
    //////////////////////////////////////////////////////////////////////
    logic [2:0]     resume_sync;
    logic [15:0]    command_register;
    logic [15:0]    controller_status;
    uhrd_state_type state;
    logic [15:0]    next_command;
    logic [15:0]    next_status;
    uhrd_state_type next_state;
    logic           frame_clear;
    logic           frame_run;
    logic           sof_pulse;
    logic           run_control_bit;
    logic           single_step_debug;
    logic           resume_rise;
    logic           cmd_wr;
    logic           sts_wr;
    logic           td_done;
    logic           step_wrap;
    logic           next_step_wrap;

    assign run_control_bit   = command_register[`UHRD_CMD_RUN];
    assign single_step_debug = command_register[`UHRD_CMD_DEBUG];
    assign resume_rise       = resume_sync[1] & ~resume_sync[2];
    assign cmd_wr = io_wr_i && (io_addr_i == `UHRD_CMD_OFFSET);
    assign sts_wr = io_wr_i && (io_addr_i == `UHRD_STS_OFFSET);
    assign td_done = (state == UHRD_EXEC) && td_valid_i;
    assign td_fetch_o = (state == UHRD_FETCH);
    assign sof_o = sof_pulse;

    // Frame counter: reset when stopped outside debug, frozen in debug
    assign frame_clear = (state == UHRD_HALTED) && !single_step_debug;
    assign frame_run   = (state != UHRD_HALTED);

    uhrd_frame_timer #(
        .FRAME_CYCLES (FRAME_CYCLES)
    ) u_frame (
        .core_clk_i (core_clk_i),
        .arst_n_i   (arst_n_i),
        .clear_i    (frame_clear),
        .count_en_i (frame_run),
        .sof_o      (sof_pulse)
    );

    //////////////////////////////////////////////////////////////////////
    // Schedule sequencer
    always_comb begin
        next_state     = state;
        next_command   = command_register;
        next_step_wrap = step_wrap;
        if (cmd_wr) begin
            next_command = io_wdata_i & `UHRD_CMD_MASK;
        end
        if (consist_err_i || host_bus_err_i) begin
            next_command[`UHRD_CMD_RUN] = 1'b0;
        end
        case (state)
            UHRD_HALTED: begin
                if (run_control_bit) begin
                    // Debug resumes mid-frame, normal restarts at SOF
                    next_state = single_step_debug ? UHRD_FETCH : UHRD_WAITSOF;
                end
            end
            UHRD_WAITSOF: begin
                if (step_wrap) begin
                    if (sof_pulse) begin
                        next_state = UHRD_FETCH;
                    end
                end else if (!run_control_bit) begin
                    // Every stop passes STOPPNG so the halted flag is raised
                    next_state = UHRD_STOPPNG;
                end else if (sof_pulse) begin
                    next_state = UHRD_FETCH;
                end
            end
            UHRD_FETCH: begin
                if (step_wrap) begin
                    next_state     = UHRD_STOPPNG;
                    next_step_wrap = 1'b0;
                end else if (!run_control_bit && !single_step_debug) begin
                    next_state = UHRD_STOPPNG;
                end else begin
                    next_state = UHRD_EXEC;
                end
            end
            UHRD_EXEC: begin
                if (td_valid_i) begin
                    if (single_step_debug && td_result_i.active) begin
                        next_command[`UHRD_CMD_RUN] = 1'b0;
                    end
                    if (single_step_debug && td_result_i.active
                        && td_result_i.last_in_frame) begin
                        // Last active step of a frame halts only after the next fetch
                        next_state     = UHRD_WAITSOF;
                        next_step_wrap = 1'b1;
                    end else if (!run_control_bit
                        || (single_step_debug && td_result_i.active)) begin
                        next_state = UHRD_STOPPNG;
                    end else if (td_result_i.last_in_frame) begin
                        next_state = UHRD_WAITSOF;
                    end else begin
                        next_state = UHRD_FETCH;
                    end
                end
            end
            UHRD_STOPPNG: begin
                next_state = UHRD_HALTED;
            end
            default: begin
                next_state = UHRD_HALTED;
            end
        endcase
    end

    //////////////////////////////////////////////////////////////////////
    // Controller status, write one to clear, set wins over clear
    always_comb begin
        next_status = controller_status;
        if (sts_wr) begin
            next_status = controller_status & ~(io_wdata_i & `UHRD_STS_MASK);
        end
        if (state == UHRD_STOPPNG) begin
            next_status[`UHRD_BIT_HALT] = 1'b1;
        end
        if (consist_err_i) begin
            next_status[`UHRD_BIT_PROC_ERR] = 1'b1;
        end
        if (host_bus_err_i) begin
            next_status[`UHRD_BIT_SYS_ERR] = 1'b1;
        end
        if (resume_rise && command_register[`UHRD_CMD_SUSPEND]) begin
            next_status[`UHRD_BIT_RESUME] = 1'b1;
        end
        if (td_done && td_result_i.error) begin
            next_status[`UHRD_BIT_USB_ERR] = 1'b1;
        end
        if (td_done && (td_result_i.complete_irq_request
            || (td_result_i.short_detect && td_result_i.short_seen))) begin
            next_status[`UHRD_BIT_XFER_IRQ] = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state             <= UHRD_HALTED;
            command_register  <= '0;
            controller_status <= `UHRD_STS_RESET;
            resume_sync       <= '0;
            step_wrap         <= 1'b0;
        end else begin
            state             <= next_state;
            command_register  <= next_command;
            controller_status <= next_status;
            resume_sync       <= {resume_sync[1:0], resume_pin_i};
            step_wrap         <= next_step_wrap;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Register read, reserved bits read zero
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            io_rdata_o <= '0;
            irq_o      <= 1'b0;
        end else begin
            irq_o <= controller_status[`UHRD_BIT_PROC_ERR]
                   | controller_status[`UHRD_BIT_SYS_ERR];
            if (io_rd_i && (io_addr_i == `UHRD_STS_OFFSET)) begin
                io_rdata_o <= controller_status & `UHRD_STS_MASK;
            end else if (io_rd_i && (io_addr_i == `UHRD_CMD_OFFSET)) begin
                io_rdata_o <= command_register;
            end else begin
                io_rdata_o <= '0;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////
    property p_fatal_stops;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (consist_err_i || host_bus_err_i) |=> !run_control_bit;
    endproperty
    a_fatal_stops: assert property (p_fatal_stops) else $error("run not cleared on error");

    property p_proc_err;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        consist_err_i |=> controller_status[`UHRD_BIT_PROC_ERR] ##1 irq_o;
    endproperty
    a_proc_err: assert property (p_proc_err) else $error("process error not flagged");

    property p_sys_err;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        host_bus_err_i |=> controller_status[`UHRD_BIT_SYS_ERR] ##1 irq_o;
    endproperty
    a_sys_err: assert property (p_sys_err) else $error("system error not flagged");

    sequence s_step_done;
        td_done && single_step_debug && td_result_i.active && !td_result_i.last_in_frame;
    endsequence
    property p_step_halt;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        s_step_done |=> !run_control_bit
            ##1 (state == UHRD_HALTED && controller_status[`UHRD_BIT_HALT]);
    endproperty
    a_step_halt: assert property (p_step_halt) else $error("step did not halt");

    property p_step_wrap;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (td_done && single_step_debug && td_result_i.active && td_result_i.last_in_frame)
        |=> (state == UHRD_WAITSOF) && !run_control_bit;
    endproperty
    a_step_wrap: assert property (p_step_wrap) else $error("step did not wrap");

    property p_skip_inactive;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (td_done && single_step_debug && !td_result_i.active && run_control_bit
         && !td_result_i.last_in_frame && !consist_err_i && !host_bus_err_i)
        |=> state == UHRD_FETCH;
    endproperty
    a_skip_inactive: assert property (p_skip_inactive) else $error("inactive not skipped");

    property p_irq_flag;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (td_done && td_result_i.complete_irq_request) |=> controller_status[`UHRD_BIT_XFER_IRQ];
    endproperty
    a_irq_flag: assert property (p_irq_flag) else $error("irq flag missing");

    property p_err_flag;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (td_done && td_result_i.error) |=> controller_status[`UHRD_BIT_USB_ERR];
    endproperty
    a_err_flag: assert property (p_err_flag) else $error("error flag missing");

    property p_reserved;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        io_rd_i && io_addr_i == `UHRD_STS_OFFSET |=> io_rdata_o[15:6] == 10'h000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

    property p_frame_reset;
        @(posedge core_clk_i) disable iff (!arst_n_i)
        (state == UHRD_WAITSOF && $past(state) == UHRD_HALTED && !single_step_debug)
        |-> !sof_pulse;
    endproperty
    a_frame_reset: assert property (p_frame_reset) else $error("frame not restarted");
endmodule // uhrd_run_debug_status

// file: rtl/uhrd_consts.svh
// Constants for the run, debug and status block
`ifndef UHRD_CONSTS_SVH
`define UHRD_CONSTS_SVH
`define UHRD_STS_OFFSET     8'h02
`define UHRD_CMD_OFFSET     8'h00
`define UHRD_STS_RESET      16'h0020
`define UHRD_STS_MASK       16'h003F
`define UHRD_CMD_MASK       16'h0029
`define UHRD_BIT_HALT       5
`define UHRD_BIT_PROC_ERR   4
`define UHRD_BIT_SYS_ERR    3
`define UHRD_BIT_RESUME     2
`define UHRD_BIT_USB_ERR    1
`define UHRD_BIT_XFER_IRQ   0
`define UHRD_CMD_RUN        0
`define UHRD_CMD_SUSPEND    3
`define UHRD_CMD_DEBUG      5
`define UHRD_FRAME_US       1000
`define UHRD_CLK_MHZ        200
`define UHRD_FRAME_CYC      (`UHRD_FRAME_US * `UHRD_CLK_MHZ)
`endif

// file: rtl/uhrd_pkg.sv
// Types for the run, debug and status block
package uhrd_pkg;
    typedef enum logic [2:0] {
        UHRD_HALTED  = 3'b000,
        UHRD_WAITSOF = 3'b001,
        UHRD_FETCH   = 3'b011,
        UHRD_EXEC    = 3'b010,
        UHRD_STOPPNG = 3'b110
    } uhrd_state_type;

    typedef struct packed {
        logic active;
        logic complete_irq_request;
        logic short_detect;
        logic short_seen;
        logic error;
        logic last_in_frame;
    } uhrd_td_result_type;
endpackage

// file: rtl/uhrd_frame_timer.sv
// Frame timer: counts the 1 ms frame, can be reset or frozen
`timescale 1ns/100ps
`include "uhrd_consts.svh"
module uhrd_frame_timer
    import uhrd_pkg::*;
#(
    parameter int FRAME_CYCLES = `UHRD_FRAME_CYC
) (
    input  wire logic core_clk_i,
    input  wire logic arst_n_i,
    input  wire logic clear_i,
    input  wire logic count_en_i,
    output logic      sof_o
);
    logic [31:0] count;
    logic [31:0] next_count;
    logic        next_sof;

    always_comb begin
        next_count = count;
        next_sof   = 1'b0;
        if (clear_i) begin
            next_count = '0;
        end else if (count_en_i) begin
            if (count == 32'(FRAME_CYCLES - 1)) begin
                next_count = '0;
                next_sof   = 1'b1;
            end else begin
                next_count = count + 32'h1;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            count <= '0;
            sof_o <= 1'b0;
        end else begin
            count <= next_count;
            sof_o <= next_sof;
        end
    end
endmodule // uhrd_frame_timer

// file: sim/uhrd_td_source.sv
// Descriptor result source standing for the devices behind the schedule
`timescale 1ns/100ps
module uhrd_td_source
    import uhrd_pkg::*;
(
    input  wire logic               core_clk_i,
    input  wire logic               arst_n_i,
    input  wire logic               td_fetch_i,
    input  wire logic [2:0]         lat_i,
    input  wire uhrd_td_result_type res_i,
    output logic                    td_valid_o,
    output uhrd_td_result_type      td_result_o
);
    logic       busy;
    logic [2:0] cnt;

    ////////////////////////////////////////////////////////////////////////
    // Answers each fetch after lat_i + 1 cycles with a one-cycle result
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            busy       <= 1'b0;
            cnt        <= 3'h0;
            td_valid_o <= 1'b0;
        end else begin
            td_valid_o <= 1'b0;
            if (td_fetch_i) begin
                busy <= 1'b1;
                cnt  <= lat_i;
            end else if (busy) begin
                if (cnt == 3'h0) begin
                    busy       <= 1'b0;
                    td_valid_o <= 1'b1;
                end else begin
                    cnt <= cnt - 3'h1;
                end
            end
        end
    end

    // Result lines carry junk outside the valid cycle
    assign td_result_o = td_valid_o ? res_i : uhrd_td_result_type'(~res_i);
endmodule // uhrd_td_source

// file: sim/uhrd_run_debug_status_tb.sv
// Testbench for the run, debug and status block
`timescale 1ns/100ps
module uhrd_run_debug_status_tb;
    import uhrd_pkg::*;
    logic               clk    = 1'b0;
    logic               arst_n = 1'b0;
    logic [7:0]         addr   = 8'h00;
    logic               wr_s   = 1'b0;
    logic               rd_s   = 1'b0;
    logic [15:0]        wdata  = 16'h0000;
    logic               cerr   = 1'b0;
    logic               berr   = 1'b0;
    logic               rsm    = 1'b0;
    uhrd_td_result_type res    = 6'h00;
    logic [15:0]        rdata;
    logic               tdv;
    uhrd_td_result_type tdr;
    logic               fetch;
    logic               sof;
    logic               irq;
    int                 n_errors = 0;
    int                 compares = 0;
    localparam int      FRAME    = 20;

    always #2.5 clk = ~clk;

    uhrd_run_debug_status #(.FRAME_CYCLES(FRAME)) dut (.core_clk_i(clk), .arst_n_i(arst_n),
        .io_addr_i(addr), .io_wr_i(wr_s), .io_rd_i(rd_s), .io_wdata_i(wdata),
        .io_rdata_o(rdata), .td_valid_i(tdv), .td_result_i(tdr), .consist_err_i(cerr),
        .host_bus_err_i(berr), .resume_pin_i(rsm), .td_fetch_o(fetch), .sof_o(sof),
        .irq_o(irq));
    uhrd_td_source src (.core_clk_i(clk), .arst_n_i(arst_n), .td_fetch_i(fetch),
        .lat_i(3'h2), .res_i(res), .td_valid_o(tdv), .td_result_o(tdr));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        addr  = a;
        wdata = d;
        wr_s  = 1'b1;
        @(negedge clk);
        wr_s  = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(negedge clk);
        addr = a;
        rd_s = 1'b1;
        @(negedge clk);
        rd_s = 1'b0;
        d    = rdata;
    endtask
    task automatic poll_halt;
        logic [15:0] v;
        v = 16'h0000;
        for (int i = 0; i < 100 && v[5] !== 1'b1; i++) rd(8'h02, v);
        chk(v & 16'h0020, 16'h0020);
    endtask
    task automatic end_of_test;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        logic [15:0] v;
        rd(8'h02, v);
        chk(v, 16'h0020);
        wr(8'h02, 16'hFFC0);
        rd(8'h02, v);
        chk(v, 16'h0020);
        rd(8'h10, v);
        chk(v, 16'h0000);
        wr(8'h02, 16'h0020);
        rd(8'h02, v);
        chk(v, 16'h0000);
    endtask
    task automatic t_run;
        logic [15:0] v;
        int          n;
        int          m;
        logic [15:0] rs [3] = '{16'h0030, 16'h0032, 16'h002C};
        logic [15:0] ex [3] = '{16'h0001, 16'h0003, 16'h0001};
        wr(8'h00, 16'h0001);
        for (int k = 0; k < 3; k++) begin
            res = uhrd_td_result_type'(rs[k][5:0]);
            wr(8'h02, 16'h003F);
            n = 0;
            repeat (60) begin
                @(negedge clk);
                n += int'(sof);
            end
            chk(n[15:0], 16'(60 / FRAME));
            rd(8'h02, v);
            chk(v, ex[k]);
        end
        wr(8'h00, 16'h0000);
        poll_halt();
        n = 0;
        m = 0;
        repeat (60) begin
            @(negedge clk);
            n += int'(sof);
            m += int'(fetch);
        end
        chk(n[15:0], 16'h0000);
        chk(m[15:0], 16'h0000);
    endtask
    task automatic t_debug;
        logic [15:0] v;
        res = 6'h00;
        wr(8'h00, 16'h0020);
        wr(8'h02, 16'h003F);
        wr(8'h00, 16'h0021);
        repeat (40) @(negedge clk);
        rd(8'h02, v);
        chk(v, 16'h0000);
        res = 6'h30;
        poll_halt();
        rd(8'h00, v);
        chk(v, 16'h0020);
        rd(8'h02, v);
        chk(v, 16'h0021);
        wr(8'h00, 16'h0000);
        wr(8'h02, 16'h003F);
        wr(8'h00, 16'h0001);
        repeat (60) @(negedge clk);
        rd(8'h02, v);
        chk(v, 16'h0001);
    endtask
    task automatic t_wrap;
        logic [15:0] v;
        wr(8'h00, 16'h0000);
        poll_halt();
        wr(8'h00, 16'h0020);
        res = 6'h31;
        wr(8'h02, 16'h003F);
        wr(8'h00, 16'h0021);
        repeat (8) @(negedge clk);
        rd(8'h02, v);
        chk(v, 16'h0001);
        poll_halt();
        rd(8'h02, v);
        chk(v, 16'h0021);
        rd(8'h00, v);
        chk(v, 16'h0020);
        wr(8'h00, 16'h0000);
    endtask
    task automatic t_fatal(input int b);
        logic [15:0] v;
        res = 6'h00;
        wr(8'h00, 16'h0001);
        wr(8'h02, 16'h003F);
        repeat (10) @(negedge clk);
        cerr = (b == 4);
        berr = (b == 3);
        @(negedge clk);
        cerr = 1'b0;
        berr = 1'b0;
        repeat (10) @(negedge clk);
        rd(8'h02, v);
        chk(v, 16'h0020 | (16'h0001 << b));
        chk({15'h0000, irq}, 16'h0001);
        rd(8'h00, v);
        chk(v, 16'h0000);
        wr(8'h02, 16'h003F);
        repeat (3) @(negedge clk);
        chk({15'h0000, irq}, 16'h0000);
    endtask
    task automatic t_resume;
        logic [15:0] v;
        rsm = 1'b1;
        repeat (6) @(negedge clk);
        rd(8'h02, v);
        chk(v, 16'h0000);
        rsm = 1'b0;
        wr(8'h00, 16'h0008);
        rsm = 1'b1;
        repeat (6) @(negedge clk);
        rd(8'h02, v);
        chk(v, 16'h0004);
        rsm = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        arst_n = 1'b1;
        t_regs();
        t_run();
        t_debug();
        t_wrap();
        t_fatal(4);
        t_fatal(3);
        t_resume();
        end_of_test();
    end
    initial begin
        #100000;
        n_errors++;
        end_of_test();
    end
endmodule // uhrd_run_debug_status_tb
